/* rtl/cfglk_top.sv */
// Configuration word, lock control, pin ownership and guarded routing registers
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`include "cfglk_params.svh"
module cfglk_top #(
	parameter int NUM_ROUTE = `CFGLK_NUM_ROUTE,
	parameter int ROUTE_W = `CFGLK_ROUTE_W,
	parameter int NUM_MDIS = `CFGLK_NUM_MDIS,
	parameter int MDIS_W = `CFGLK_MDIS_W
) (
	input wire logic pclk, // Bus clock, 250 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [`CFGLK_ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [31:0] cfg_word_in, // Nonvolatile config word
	input wire logic pwr_pad_in, // Power-switch pad level
	output cfglk_pkg::cfglk_drive_s pwr_pad, // Power-switch pad drive
	input wire cfglk_pkg::cfglk_drive_s usb_pwr, // USB drive for power pin
	input wire cfglk_pkg::cfglk_drive_s gpio_pwr, // Port drive for power pin
	output logic gpio_pwr_in, // Power pin level to port
	input wire logic id_pad_in, // Ident pad level
	output cfglk_pkg::cfglk_drive_s id_pad, // Ident pad drive
	input wire cfglk_pkg::cfglk_drive_s gpio_id, // Port drive for ident pin
	output logic usb_ident_in, // Ident level to USB
	output logic gpio_id_in, // Ident level to port
	output logic [15:0] user_identifier, // Id for programming and scan ports
	output logic scan_port_enable, // Scan port enabled
	output logic two_wire_out_use, // Two-wire scan uses data out
	output logic [NUM_ROUTE*ROUTE_W-1:0] pin_routing_registers, // Routing selects
	output logic [NUM_MDIS*MDIS_W-1:0] module_disable_registers // Module disables
);
	import cfglk_pkg::*;

	localparam int RIDX_W = (NUM_ROUTE > 1) ? $clog2(NUM_ROUTE) : 1;
	localparam int MIDX_W = (NUM_MDIS > 1) ? $clog2(NUM_MDIS) : 1;

	// Config word capture
	logic [31:0] cfg_sync1_reg;
	logic [31:0] cfg_sync2_reg;
	logic [1:0] cap_cnt_reg;
	logic cfg_valid_reg;
	cfglk_cfg_word_s cfg_word_reg;

	// Word is static while running but crosses in from the fuse array
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_sync1_reg <= `CFGLK_CFG_WORD_RST;
			cfg_sync2_reg <= `CFGLK_CFG_WORD_RST;
		end else begin
			cfg_sync1_reg <= cfg_word_in;
			cfg_sync2_reg <= cfg_sync1_reg;
		end
	end

	// Captured once after reset so owners cannot glitch mid-run
	wire cap_now = !cfg_valid_reg && (cap_cnt_reg == `CFGLK_CAPTURE_DELAY);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cap_cnt_reg <= 2'h0;
		else if (!cfg_valid_reg)
			cap_cnt_reg <= cap_cnt_reg + 2'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cfg_valid_reg <= 1'b0;
		else if (cap_now)
			cfg_valid_reg <= 1'b1;
	end

	// Later fuse changes are ignored until the next reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cfg_word_reg <= `CFGLK_CFG_WORD_RST;
		else if (cap_now)
			cfg_word_reg <= cfg_sync2_reg;
	end

	wire own_pwr_usb = cfg_word_reg.power_switch_pin_owner_sel;
	wire own_id_usb = cfg_word_reg.id_pin_owner_sel;
	wire route_one_shot = cfg_word_reg.pin_route_one_shot;
	wire mdis_one_shot = cfg_word_reg.module_disable_one_shot;
	wire [31:0] cfg_word_rd = cfg_word_reg;

	assign user_identifier = cfg_word_reg.user_identifier;

	// Pad input synchronisers
	logic pwr_sync1_reg;
	logic pwr_sync2_reg;
	logic id_sync1_reg;
	logic id_sync2_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_sync1_reg <= 1'b0;
			pwr_sync2_reg <= 1'b0;
		end else begin
			pwr_sync1_reg <= pwr_pad_in;
			pwr_sync2_reg <= pwr_sync1_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			id_sync1_reg <= 1'b0;
			id_sync2_reg <= 1'b0;
		end else begin
			id_sync1_reg <= id_pad_in;
			id_sync2_reg <= id_sync2_next_src(id_sync1_reg);
		end
	end

	function automatic logic id_sync2_next_src(input logic v);
		id_sync2_next_src = v;
	endfunction

	// Ownership muxes; the non-owner sees a quiet low level
	assign pwr_pad = own_pwr_usb ? usb_pwr : gpio_pwr;
	assign gpio_pwr_in = own_pwr_usb ? 1'b0 : pwr_sync2_reg;
	assign id_pad = own_id_usb ? '0 : gpio_id;
	assign usb_ident_in = own_id_usb ? id_sync2_reg : 1'b0;
	assign gpio_id_in = own_id_usb ? 1'b0 : id_sync2_reg;

	// APB decode
	// Register map, one word each:
	//   0x00 config word, read only; writes ignored
	//   0x04 lock control
	//   0x08 unlock key, write only, reads zero
	//   0x0C status, write one to clear refusal flags
	//   0x40 + 4*i routing entry i
	//   0x80 + 4*i module-disable entry i
	// Anything else answers with an error
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;

	wire [1:0] region = paddr[`CFGLK_REGION_LSB +: 2];
	wire aligned = (paddr[1:0] == 2'h0);
	wire [RIDX_W-1:0] route_idx = paddr[2 +: RIDX_W];
	wire [MIDX_W-1:0] mdis_idx = paddr[2 +: MIDX_W];
	wire [`CFGLK_ADDR_W-1:0] route_top = paddr >> (2 + RIDX_W);
	wire [`CFGLK_ADDR_W-1:0] mdis_top = paddr >> (2 + MIDX_W);
	wire [`CFGLK_ADDR_W-1:0] route_top_ok = `CFGLK_ADDR_W'(`CFGLK_REGION_ROUTE) << (`CFGLK_REGION_LSB - 2 - RIDX_W);
	wire [`CFGLK_ADDR_W-1:0] mdis_top_ok = `CFGLK_ADDR_W'(`CFGLK_REGION_MDIS) << (`CFGLK_REGION_LSB - 2 - MIDX_W);

	wire sel_cfg = (paddr == `CFGLK_OFS_CFG);
	wire sel_lock = (paddr == `CFGLK_OFS_LOCK);
	wire sel_key = (paddr == `CFGLK_OFS_KEY);
	wire sel_stat = (paddr == `CFGLK_OFS_STAT);
	wire sel_route = aligned && (region == `CFGLK_REGION_ROUTE) && (route_top == route_top_ok)
		&& (32'(route_idx) < NUM_ROUTE);
	wire sel_mdis = aligned && (region == `CFGLK_REGION_MDIS) && (mdis_top == mdis_top_ok)
		&& (32'(mdis_idx) < NUM_MDIS);
	wire mapped = sel_cfg || sel_lock || sel_key || sel_stat || sel_route || sel_mdis;

	wire access = psel && penable;
	wire done = access && pready_reg;
	wire wr_done = done && pwrite;

	// Lock control and status state
	logic route_lock_reg;
	logic mdis_lock_reg;
	logic scan_en_reg;
	logic two_wire_reg;
	logic route_ref_reg;
	logic mdis_ref_reg;
	logic unlocked;

	wire route_refuse = sel_route && pwrite && route_lock_reg;
	wire mdis_refuse = sel_mdis && pwrite && mdis_lock_reg;
	wire err_now = !mapped || route_refuse || mdis_refuse;

	wire key_wr_s = wr_done && sel_key;
	wire ctrl_wr = wr_done && sel_lock;

	cfglk_unlock u_unlock (
		.pclk(pclk),
		.presetn(presetn),
		.key_wr(key_wr_s),
		.key_data(pwdata),
		.relock(ctrl_wr),
		.unlocked(unlocked)
	);

	// Lock bit may move only while unlocked; one-shot pins a set bit
	wire route_lock_wr = ctrl_wr && unlocked;
	wire mdis_lock_wr = ctrl_wr && unlocked;
	wire route_lock_next = (route_one_shot && route_lock_reg) ? 1'b1
		: pwdata[`CFGLK_BIT_ROUTE_LOCK];
	wire mdis_lock_next = (mdis_one_shot && mdis_lock_reg) ? 1'b1
		: pwdata[`CFGLK_BIT_MDIS_LOCK];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			route_lock_reg <= `CFGLK_ROUTE_LOCK_RST;
		else if (route_lock_wr)
			route_lock_reg <= route_lock_next;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mdis_lock_reg <= `CFGLK_MDIS_LOCK_RST;
		else if (mdis_lock_wr)
			mdis_lock_reg <= mdis_lock_next;
	end

	// Scan controls need no unlock sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			scan_en_reg <= `CFGLK_SCAN_EN_RST;
		else if (ctrl_wr)
			scan_en_reg <= pwdata[`CFGLK_BIT_SCAN_EN];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			two_wire_reg <= `CFGLK_TWO_WIRE_RST;
		else if (ctrl_wr)
			two_wire_reg <= pwdata[`CFGLK_BIT_TWO_WIRE];
	end

	assign scan_port_enable = scan_en_reg;
	assign two_wire_out_use = two_wire_reg;

	// Refused-write flags: new refusal wins over a write-one clear
	wire st_clr = wr_done && sel_stat;
	wire route_ref_set = wr_done && route_refuse;
	wire mdis_ref_set = wr_done && mdis_refuse;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			route_ref_reg <= 1'b0;
		else if (route_ref_set)
			route_ref_reg <= 1'b1;
		else if (st_clr && pwdata[`CFGLK_BIT_ST_ROUTE_REF])
			route_ref_reg <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mdis_ref_reg <= 1'b0;
		else if (mdis_ref_set)
			mdis_ref_reg <= 1'b1;
		else if (st_clr && pwdata[`CFGLK_BIT_ST_MDIS_REF])
			mdis_ref_reg <= 1'b0;
	end

	// Guarded register banks
	// Lock is checked at the completing edge, not at setup
	logic [ROUTE_W-1:0] route_reg [NUM_ROUTE];
	logic [MDIS_W-1:0] mdis_reg [NUM_MDIS];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_ROUTE; gi++) begin : g_route
			wire hit = wr_done && sel_route && !route_lock_reg && (32'(route_idx) == gi);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					route_reg[gi] <= '0;
				else if (hit)
					route_reg[gi] <= pwdata[ROUTE_W-1:0];
			end
			assign pin_routing_registers[gi*ROUTE_W +: ROUTE_W] = route_reg[gi];
		end
		for (gi = 0; gi < NUM_MDIS; gi++) begin : g_mdis
			wire hit = wr_done && sel_mdis && !mdis_lock_reg && (32'(mdis_idx) == gi);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					mdis_reg[gi] <= '0;
				else if (hit)
					mdis_reg[gi] <= pwdata[MDIS_W-1:0];
			end
			assign module_disable_registers[gi*MDIS_W +: MDIS_W] = mdis_reg[gi];
		end
	endgenerate

	// Read data assembly
	logic [31:0] lock_rd;
	always_comb begin
		lock_rd = `CFGLK_LOCK_ONES;
		lock_rd[`CFGLK_BIT_ROUTE_LOCK] = route_lock_reg;
		lock_rd[`CFGLK_BIT_MDIS_LOCK] = mdis_lock_reg;
		lock_rd[`CFGLK_BIT_SCAN_EN] = scan_en_reg;
		lock_rd[`CFGLK_BIT_TWO_WIRE] = two_wire_reg;
	end

	logic [31:0] stat_rd;
	always_comb begin
		stat_rd = 32'h0000_0000;
		stat_rd[`CFGLK_BIT_ST_UNLOCKED] = unlocked;
		stat_rd[`CFGLK_BIT_ST_CFG_VALID] = cfg_valid_reg;
		stat_rd[`CFGLK_BIT_ST_ROUTE_REF] = route_ref_reg;
		stat_rd[`CFGLK_BIT_ST_MDIS_REF] = mdis_ref_reg;
	end

	wire [31:0] route_rd = 32'(route_reg[route_idx]);
	wire [31:0] mdis_rd = 32'(mdis_reg[mdis_idx]);
	wire [31:0] rd_mux = sel_cfg ? cfg_word_rd
		: sel_lock ? lock_rd
		: sel_stat ? stat_rd
		: sel_route ? route_rd
		: sel_mdis ? mdis_rd
		: 32'h0000_0000;

	// One wait state so read data leaves a flip-flop
	wire first_acc = access && !pready_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready_reg <= 1'b0;
		else
			pready_reg <= first_acc;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pslverr_reg <= 1'b0;
		else
			pslverr_reg <= first_acc && err_now;
	end

	// Holds the last transfer's word between transfers; a write leaves zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else if (first_acc)
			prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;
endmodule // cfglk_top

/* include/cfglk_params.svh */
// Constants for the configuration word and lock control block
// Overview of operation
// - Config bit 31 high hands the power-switch pin to USB, low to the port.
// - Config bit 30 high hands the identification pin to USB, low to the port.
// - Config bit 29 high allows one pin-routing reconfiguration, low allows many.
// - Config bit 28 high allows one module-disable reconfiguration, low allows many.
// - Config bits 15:0 hold a user identifier, readable by programming and scan ports.
// - Lock bit 13 blocks pin-routing register writes while set; resets to zero.
// - Lock bit 12 blocks module-disable register writes while set; resets to zero.
// - A lock bit changes only after the unlock sequence has been performed.
// - Lock control bit 3 enables the scan port; resets to one.
// - Lock control bit 0 selects output use in two-wire scan; resets to one.
// - Lock control bits 2:1 read one; bits 31:14 and 11:4 read zero.
`ifndef CFGLK_PARAMS_SVH
`define CFGLK_PARAMS_SVH

`define CFGLK_ADDR_W 8
`define CFGLK_OFS_CFG 8'h00
`define CFGLK_OFS_LOCK 8'h04
`define CFGLK_OFS_KEY 8'h08
`define CFGLK_OFS_STAT 8'h0C
`define CFGLK_REGION_LSB 6
`define CFGLK_REGION_CTRL 2'h0
`define CFGLK_REGION_ROUTE 2'h1
`define CFGLK_REGION_MDIS 2'h2

`define CFGLK_BIT_PWR_OWNER 31
`define CFGLK_BIT_ID_OWNER 30
`define CFGLK_BIT_ROUTE_ONE 29
`define CFGLK_BIT_MDIS_ONE 28
`define CFGLK_RSVD_HI 27
`define CFGLK_RSVD_LO 16
`define CFGLK_UID_HI 15
`define CFGLK_UID_LO 0
`define CFGLK_CFG_WORD_RST 32'hFFFF_FFFF

`define CFGLK_BIT_ROUTE_LOCK 13
`define CFGLK_BIT_MDIS_LOCK 12
`define CFGLK_BIT_SCAN_EN 3
`define CFGLK_BIT_TWO_WIRE 0
`define CFGLK_LOCK_ONES 32'h0000_0006
`define CFGLK_ROUTE_LOCK_RST 1'b0
`define CFGLK_MDIS_LOCK_RST 1'b0
`define CFGLK_SCAN_EN_RST 1'b1
`define CFGLK_TWO_WIRE_RST 1'b1

`define CFGLK_BIT_ST_UNLOCKED 0
`define CFGLK_BIT_ST_CFG_VALID 1
`define CFGLK_BIT_ST_ROUTE_REF 2
`define CFGLK_BIT_ST_MDIS_REF 3

`define CFGLK_KEY_FIRST 32'hAA99_6655
`define CFGLK_KEY_SECOND 32'h5566_99AA
`define CFGLK_CAPTURE_DELAY 2'h3
`define CFGLK_NUM_ROUTE 8
`define CFGLK_ROUTE_W 4
`define CFGLK_NUM_MDIS 4
`define CFGLK_MDIS_W 32

`endif

/* include/cfglk_pkg.sv */
// Types shared by the configuration lock block
package cfglk_pkg;
	typedef struct packed {
		logic out;
		logic oe;
	} cfglk_drive_s;

	typedef struct packed {
		logic power_switch_pin_owner_sel;
		logic id_pin_owner_sel;
		logic pin_route_one_shot;
		logic module_disable_one_shot;
		logic [11:0] reserved;
		logic [15:0] user_identifier;
	} cfglk_cfg_word_s;

	typedef enum logic [1:0] {
		CFGLK_UL_IDLE = 2'b00,
		CFGLK_UL_HALF = 2'b01,
		CFGLK_UL_OPEN = 2'b10
	} cfglk_unlock_e;
endpackage

/* rtl/cfglk_unlock.sv */
// Two-key unlock sequencer guarding the lock bits
`timescale 1ns/1ns
`include "cfglk_params.svh"
module cfglk_unlock (
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Async reset, active low
	input wire logic key_wr, // Write to key register completes
	input wire logic [31:0] key_data, // Written key value
	input wire logic relock, // Lock control write completes
	output logic unlocked // Sequence performed
);
	import cfglk_pkg::*;

	cfglk_unlock_e state_reg;
	cfglk_unlock_e state_next;

	wire first_ok = (key_data == `CFGLK_KEY_FIRST);
	wire second_ok = (key_data == `CFGLK_KEY_SECOND);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CFGLK_UL_IDLE: begin
				if (key_wr && first_ok)
					state_next = CFGLK_UL_HALF;
			end
			CFGLK_UL_HALF: begin
				// Any other key value aborts the sequence
				if (key_wr)
					state_next = second_ok ? CFGLK_UL_OPEN : CFGLK_UL_IDLE;
			end
			CFGLK_UL_OPEN: begin
				// Unlock is spent by one lock control write or one key write
				if (relock || key_wr)
					state_next = CFGLK_UL_IDLE;
			end
			default: state_next = CFGLK_UL_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= CFGLK_UL_IDLE;
		else
			state_reg <= state_next;
	end

	assign unlocked = (state_reg == CFGLK_UL_OPEN);
endmodule // cfglk_unlock

/* verif/cfglk_checker.sv */
// Bus and lock relations checker for the configuration lock block
`timescale 1ns/1ns
module cfglk_checker #(
	parameter int NUM_ROUTE = 8,
	parameter int ROUTE_W = 4,
	parameter int NUM_MDIS = 4,
	parameter int MDIS_W = 32
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic psel, // Bus
	input wire logic penable, // Bus
	input wire logic pwrite, // Bus
	input wire logic [7:0] paddr, // Bus
	input wire logic [31:0] pwdata, // Bus
	input wire logic [31:0] prdata, // Bus
	input wire logic pready, // Bus
	input wire logic pslverr, // Bus
	input wire logic [31:0] cfg_word_in, // Config
	input wire logic pwr_pad_in, // Pad
	input wire cfglk_pkg::cfglk_drive_s pwr_pad, // Pad
	input wire cfglk_pkg::cfglk_drive_s usb_pwr, // Pad
	input wire cfglk_pkg::cfglk_drive_s gpio_pwr, // Pad
	input wire logic gpio_pwr_in, // Pad
	input wire logic id_pad_in, // Pad
	input wire cfglk_pkg::cfglk_drive_s id_pad, // Pad
	input wire cfglk_pkg::cfglk_drive_s gpio_id, // Pad
	input wire logic usb_ident_in, // Pad
	input wire logic gpio_id_in, // Pad
	input wire logic [15:0] user_identifier, // Id
	input wire logic scan_port_enable, // Lock ctrl
	input wire logic two_wire_out_use, // Lock ctrl
	input wire logic [NUM_ROUTE*ROUTE_W-1:0] pin_routing_registers, // Bank
	input wire logic [NUM_MDIS*MDIS_W-1:0] module_disable_registers // Bank
);
	import cfglk_pkg::*;
	// Config word is only trusted once the capture has surely landed
	logic [2:0] up_cnt;
	wire settled = (up_cnt == 3'h7);
	wire done = psel && penable && pready;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up_cnt <= 3'h0;
		else if (up_cnt != 3'h7)
			up_cnt <= up_cnt + 3'h1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pwr_owner_mux: assert property (settled |-> pwr_pad == (cfg_word_in[31] ? usb_pwr : gpio_pwr))
		else $error("power pin drive owner wrong");
	a_pwr_nonowner_in: assert property (settled && cfg_word_in[31] |-> !gpio_pwr_in)
		else $error("port sees power pin it does not own");
	a_id_owner_mux: assert property (settled |-> id_pad == (cfg_word_in[30] ? 2'h0 : gpio_id))
		else $error("ident pin drive owner wrong");
	a_user_id_out: assert property (settled |-> user_identifier == cfg_word_in[15:0])
		else $error("user identifier mismatch");
	a_cfg_read: assert property (settled && done && !pwrite && paddr == 8'h00 |-> prdata == cfg_word_in)
		else $error("config word read wrong");
	a_lock_read_bits: assert property (done && !pwrite && paddr == 8'h04 |-> prdata[31:14] == 18'h0 &&
		prdata[11:4] == 8'h0 && prdata[2:1] == 2'h3 && prdata[3] == scan_port_enable && prdata[0] == two_wire_out_use)
		else $error("lock control read wrong");
	a_refused_hold: assert property (done && pwrite && pslverr |=> $stable(pin_routing_registers) &&
		$stable(module_disable_registers))
		else $error("refused write changed a bank");
	a_route_write: assert property (done && pwrite && !pslverr && paddr == 8'h40 |=>
		pin_routing_registers[3:0] == $past(pwdata[3:0]))
		else $error("accepted routing write lost");
	a_scan_reset: assert property ($rose(presetn) |-> scan_port_enable && two_wire_out_use)
		else $error("scan controls not set after reset");
	a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("wait state count wrong");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	c_refused: cover property (done && pwrite && pslverr);
	c_route_ok: cover property (done && pwrite && !pslverr && paddr == 8'h40);
	c_lock_read: cover property (done && !pwrite && paddr == 8'h04 && prdata[13]);
endmodule // cfglk_checker

bind cfglk_top cfglk_checker #(.NUM_ROUTE(NUM_ROUTE), .ROUTE_W(ROUTE_W), .NUM_MDIS(NUM_MDIS), .MDIS_W(MDIS_W)) i_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cfg_word_in,
	.pwr_pad_in, .pwr_pad, .usb_pwr, .gpio_pwr, .gpio_pwr_in, .id_pad_in, .id_pad, .gpio_id, .usb_ident_in,
	.gpio_id_in, .user_identifier, .scan_port_enable, .two_wire_out_use, .pin_routing_registers,
	.module_disable_registers);

/* verif/cfglk_top_tb.sv */
// Register level bench for the configuration lock block
`timescale 1ns/1ns
`include "cfglk_params.svh"
module cfglk_top_tb;
	import cfglk_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, cfg_word_in = 32'h0, prdata;
	logic pready, pslverr, gpio_pwr_in, usb_ident_in, gpio_id_in, scan_port_enable, two_wire_out_use;
	logic pwr_pad_in = 1'b1, id_pad_in = 1'b1;
	cfglk_drive_s pwr_pad, id_pad;
	cfglk_drive_s usb_pwr = 2'h2, gpio_pwr = 2'h1, gpio_id = 2'h3;
	logic [15:0] user_identifier;
	logic [31:0] pin_routing_registers;
	logic [127:0] module_disable_registers;
	int n_errors = 0, samples_checked = 0, cycles = 0;
	always #2 pclk = ~pclk;
	cfglk_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.cfg_word_in, .pwr_pad_in, .pwr_pad, .usb_pwr, .gpio_pwr, .gpio_pwr_in, .id_pad_in, .id_pad, .gpio_id,
		.usb_ident_in, .gpio_id_in, .user_identifier, .scan_port_enable, .two_wire_out_use,
		.pin_routing_registers, .module_disable_registers);
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			$display("[FAIL] %0t run too long", $time);
			report_and_stop;
		end
	end
	task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Leading edge keeps a new request off the edge that released the last one
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		expect_eq({31'h0, e}, {31'h0, err}, "write error flag");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		expect_eq(r, exp, "read data");
		expect_eq({31'h0, e}, 32'h0, "read error flag");
	endtask
	task automatic unlock;
		wr(`CFGLK_OFS_KEY, `CFGLK_KEY_FIRST, 1'b0);
		wr(`CFGLK_OFS_KEY, `CFGLK_KEY_SECOND, 1'b0);
	endtask
	task automatic phase(input logic [31:0] cfg);
		logic [31:0] r;
		logic e;
		@(posedge pclk);
		presetn <= 1'b0;
		cfg_word_in <= cfg;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(8'h00, cfg);
		expect_eq({16'h0, user_identifier}, {16'h0, cfg[15:0]}, "user id");
		rd(8'h04, 32'h0000_000F);
		expect_eq({30'h0, pwr_pad}, {30'h0, cfg[31] ? usb_pwr : gpio_pwr}, "power pin drive");
		expect_eq({30'h0, id_pad}, {30'h0, cfg[30] ? 2'h0 : gpio_id}, "ident pin drive");
		expect_eq({29'h0, gpio_pwr_in, usb_ident_in, gpio_id_in}, {29'h0, !cfg[31], cfg[30], !cfg[30]}, "pins in");
		wr(8'h40, 32'h5, 1'b0);
		rd(8'h40, 32'h5);
		expect_eq({28'h0, pin_routing_registers[3:0]}, 32'h5, "routing port");
		wr(8'h04, 32'h0000_3000, 1'b0);
		rd(8'h04, 32'h0000_0006);
		expect_eq({30'h0, scan_port_enable, two_wire_out_use}, 32'h0, "scan controls");
		unlock();
		wr(8'h04, 32'h0000_3009, 1'b0);
		rd(8'h04, 32'h0000_300F);
		wr(8'h40, 32'hA, 1'b1);
		rd(8'h40, 32'h5);
		wr(8'h80, 32'h1234, 1'b1);
		rd(8'h80, 32'h0);
		rd(8'h0C, 32'h0000_000E);
		wr(8'h0C, 32'h0000_000C, 1'b0);
		rd(8'h0C, 32'h0000_0002);
		unlock();
		wr(8'h04, 32'h0000_0009, 1'b0);
		rd(8'h04, {18'h0, cfg[29], cfg[28], 8'h0, 4'hF});
		wr(8'h40, 32'h3, cfg[29]);
		wr(8'h80, 32'h77, cfg[28]);
		rd(8'h80, cfg[28] ? 32'h0 : 32'h77);
		expect_eq(module_disable_registers[31:0], cfg[28] ? 32'h0 : 32'h77, "disable port");
		wr(8'h00, 32'h0, 1'b0);
		rd(8'h00, cfg);
		apb(1'b0, 8'h20, 32'h0, r, e);
		expect_eq({31'h0, e}, 32'h1, "unmapped error");
		$display("phase done for config %h", cfg);
	endtask
	initial begin
		// One-shot case first, then many-times with both pins on the port
		phase(32'hFFFF_A5C3);
		phase(32'h0FFF_3C5A);
		report_and_stop;
	end
endmodule // cfglk_top_tb
